// [design/tnss_pkg.sv]
// Package for the node status and second setup register bank.
// Assumes a 250 MHz system clock and an 8-bit register port with a 3-bit address.
package tnss_pkg;

	// ----------------------------------------------------------------------
	// Clock and timing
	// ----------------------------------------------------------------------
	localparam int unsigned CLK_MHZ        = 250;
	localparam int unsigned LINE_IDLE_NS   = 41000;
	localparam int unsigned LINE_IDLE_CYC  = LINE_IDLE_NS * CLK_MHZ / 1000;
	localparam int unsigned RECON_SEL0_US  = 420000;
	localparam int unsigned RECON_SEL1_US  = 105000;
	localparam int unsigned RECON_SEL2_NS  = 52500000;
	localparam int unsigned RECON_SEL3_NS  = 26250000;
	localparam int unsigned RECON_SEL0_CYC = RECON_SEL0_US * CLK_MHZ;
	localparam int unsigned RECON_SEL1_CYC = RECON_SEL1_US * CLK_MHZ;
	localparam int unsigned RECON_SEL2_CYC = RECON_SEL2_NS / 1000 * CLK_MHZ;
	localparam int unsigned RECON_SEL3_CYC = RECON_SEL3_NS / 1000 * CLK_MHZ;
	localparam int unsigned RATE_SHIFT_MAX = 5;
	localparam int unsigned TIMER_W        = 32;

	// ----------------------------------------------------------------------
	// Register addresses
	// ----------------------------------------------------------------------
	localparam logic [2:0] ADDR_STATUS   = 3'h0;
	localparam logic [2:0] ADDR_COMMAND  = 3'h1;
	localparam logic [2:0] ADDR_IMR      = 3'h2;
	localparam logic [2:0] ADDR_NODE_ID  = 3'h3;
	localparam logic [2:0] ADDR_CONFIG   = 3'h4;
	localparam logic [2:0] ADDR_SUBSEL   = 3'h5;
	localparam logic [2:0] ADDR_SUBREG   = 3'h7;
	localparam logic [2:0] SUBSEL_NETWORK_SETUP_TWO = 3'h4;

	// ----------------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------------
	localparam int unsigned ST_RI           = 7;
	localparam int unsigned ST_POR          = 4;
	localparam int unsigned ST_RECON        = 2;
	localparam int unsigned ST_TA           = 0;
	localparam int unsigned S2_CKUP_LSB     = 0;
	localparam int unsigned S2_FAST_READ    = 2;
	localparam int unsigned S2_ENH_TIMING   = 3;
	localparam int unsigned S2_NO_IDLE_INIT = 4;
	localparam int unsigned S2_RCN_LSB      = 5;
	localparam int unsigned CMD_PAGE_LSB    = 3;

	// ----------------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------------
	localparam logic [7:0] CFG_RST     = 8'h18;
	localparam logic [7:0] NETWORK_SETUP_TWO_RST  = 8'h00;
	localparam logic [7:0] IMR_RST     = 8'h00;
	localparam logic [7:0] NODE_ID_RST = 8'h00;
	localparam logic [7:0] STATUS_RST  = 8'h91;

	// ----------------------------------------------------------------------
	// Command opcodes, low three bits of a command write
	// ----------------------------------------------------------------------
	localparam logic [2:0] CMD_DISABLE_TX  = 3'h1;
	localparam logic [2:0] CMD_ENABLE_TX   = 3'h2;
	localparam logic [2:0] CMD_ENABLE_RX   = 3'h3;
	localparam logic [2:0] CMD_CLEAR_FLAGS = 3'h4;
	localparam logic [2:0] CMD_SOFT_RESET  = 3'h5;

endpackage : tnss_pkg

// [design/tnss_timer_if.sv]
// Interface between the register bank and its down-counting timers.
// Assumes both ends run on the system clock.
`timescale 1ns/100ps
interface tnss_timer_if #(
	parameter int unsigned W = 32
);
	logic         restart;
	logic         run;
	logic [W-1:0] period;
	logic         expired;

	modport ctl (output restart, output run, output period, input expired);
	modport tmr (input restart, input run, input period, output expired);
endinterface : tnss_timer_if

// [design/tnss_timer.sv]
// Reloading down-counter that pulses once per elapsed period.
// Assumes period is at least 2 and held stable while the timer runs.
`timescale 1ns/100ps
module tnss_timer #(
	parameter int unsigned W = 32
) (
	input  wire logic i_clk_sys,
	input  wire logic i_rst_n,
	tnss_timer_if.tmr tif
);

	typedef struct packed {
		logic [W-1:0] count;
		logic         expired;
		logic         armed;
	} tnss_tmr_state_t;

	tnss_tmr_state_t s_reg;
	tnss_tmr_state_t s_next;

	if (W < 2 || $bits(tif.period) != W) begin : g_chk
		$error("tnss_timer: width does not match the interface");
	end

	// ----------------------------------------------------------------------
	// Counter
	// ----------------------------------------------------------------------
	always_comb begin
		s_next = s_reg;
		s_next.expired = 1'b0;
		// Leaving reset, a timer loads a whole period before it may fire.
		if (tif.restart || (tif.run && !s_reg.armed)) begin
			s_next.count = tif.period - W'(1);
			s_next.armed = 1'b1;
		end else if (tif.run) begin
			if (s_reg.count == '0) begin
				s_next.expired = 1'b1;
				s_next.count = tif.period - W'(1);
			end else begin
				s_next.count = s_reg.count - W'(1);
			end
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign tif.expired = s_reg.expired;

endmodule : tnss_timer

// [design/tnss_status_setup.sv]
// Node status register, second setup register and their host port.
// Assumes a host on the plain register port and node core logic on the same clock;
// only the receive line input comes from a pin.
//
// Behaviour
// - Setup two is 8-bit RW, sub-addressed.
// - Multiplier select bits choose generated clock.
// - Fast read bit enables fast host reads.
// - Enhanced timing bit picks legacy or new.
// - RAM init waits idle unless override set.
// - Timeout select picks 420/105/52.5/26.25 ms.
// - Timeouts scale with slower data rate; here only the reconfiguration timeout does, not the line idle timeout.
// - Receiver inhibited at reset and after packet.
// - Enable-receive command clears receiver inhibited.
// - Inhibited receiver answers buffer enquiry negatively.
// - Masked inhibited, recon, available raise interrupt.
// - Reset flag: resets or zero node id.
// - Test bit reads zero.
// - Status bits 6 and 5 reserved.
// - Line idle timeout sets reconfiguration flag.
// - Clear-flags command clears reconfiguration flag.
// - Acknowledged non-broadcast transmit sets acknowledged flag.
// - Enable-transmit command clears acknowledged flag.
// - Last byte or disable sets transmitter available.
// - Enable-transmit clears available at next token.
// - Status resets to 1XX1 0001.
// - Config write clears top sub-address bit.
`timescale 1ns/100ps
module tnss_status_setup
	import tnss_pkg::*;
#(
	parameter int unsigned LINE_IDLE_CYCLES = LINE_IDLE_CYC,
	parameter int unsigned RECON_CYCLES_0   = RECON_SEL0_CYC,
	parameter int unsigned RECON_CYCLES_1   = RECON_SEL1_CYC,
	parameter int unsigned RECON_CYCLES_2   = RECON_SEL2_CYC,
	parameter int unsigned RECON_CYCLES_3   = RECON_SEL3_CYC
) (
	input  wire logic       i_clk_sys,
	input  wire logic       i_rst_n,
	input  wire logic [2:0] i_addr,
	input  wire logic [7:0] i_wdata,
	input  wire logic       i_wr,
	input  wire logic       i_rd,
	output logic      [7:0] o_rdata,
	input  wire logic       i_receive_input,
	input  wire logic       i_pkt_stored,
	input  wire logic       i_tx_last_byte,
	input  wire logic       i_tx_acked,
	input  wire logic       i_tx_broadcast,
	input  wire logic       i_token_rcvd,
	input  wire logic       i_fbe_enquiry,
	input  wire logic       i_init_req,
	input  wire logic       i_recon_timer_run,
	input  wire logic [2:0] i_rate_shift,
	output logic            o_irq,
	output logic            o_receiver_inhibited,
	output logic            o_fbe_nak,
	output logic            o_fbe_ack,
	output logic      [1:0] o_clock_multiplier_select,
	output logic            o_fast_read_enable,
	output logic            o_enhanced_timing_enable,
	output logic            o_init_write_go,
	output logic            o_recon_timeout,
	output logic            o_tx_pending,
	output logic      [4:0] o_rx_page,
	output logic      [4:0] o_tx_page,
	output logic      [7:0] o_node_id
);

	// ----------------------------------------------------------------------
	// Parameter checks
	// ----------------------------------------------------------------------
	localparam logic [TIMER_W-1:0] SCALE_LIMIT = {TIMER_W{1'b1}} >> RATE_SHIFT_MAX;

	if (LINE_IDLE_CYCLES < 2) begin : g_chk_idle
		$error("tnss_status_setup: line idle count too small");
	end
	if (RECON_CYCLES_3 < 2 || RECON_CYCLES_2 < 2 || RECON_CYCLES_1 < 2 || RECON_CYCLES_0 < 2) begin : g_chk_rmin
		$error("tnss_status_setup: reconfiguration count too small");
	end
	if (RECON_CYCLES_0 > SCALE_LIMIT || RECON_CYCLES_1 > SCALE_LIMIT) begin : g_chk_rmax
		$error("tnss_status_setup: reconfiguration count overflows when scaled");
	end
	if (RECON_CYCLES_2 > SCALE_LIMIT || RECON_CYCLES_3 > SCALE_LIMIT) begin : g_chk_rmax_short
		$error("tnss_status_setup: reconfiguration count overflows when scaled");
	end
	if (RATE_SHIFT_MAX > 7) begin : g_chk_shift
		$error("tnss_status_setup: rate shift limit does not fit three bits");
	end

	// ----------------------------------------------------------------------
	// State
	// ----------------------------------------------------------------------
	typedef struct packed {
		logic       rx_meta;
		logic       rx_sync;
		logic [2:0] subsel;
		logic [7:0] cfg;
		logic [7:0] network_setup_two;
		logic [7:0] interrupt_mask_register;
		logic [7:0] node_id;
		logic       ri;
		logic       por;
		logic       recon;
		logic       tma;
		logic       ta;
		logic       tx_pending;
		logic [4:0] rx_page;
		logic [4:0] tx_page;
		logic [7:0] rdata;
		logic       irq;
		logic       fbe_nak;
		logic       fbe_ack;
		logic       init_go;
		logic       recon_timeout;
	} tnss_state_t;

	localparam tnss_state_t S_RST = '{
		rx_meta:       1'b0,
		rx_sync:       1'b0,
		subsel:        3'h0,
		cfg:           CFG_RST,
		network_setup_two:        NETWORK_SETUP_TWO_RST,
		interrupt_mask_register:           IMR_RST,
		node_id:       NODE_ID_RST,
		ri:            STATUS_RST[ST_RI],
		por:           STATUS_RST[ST_POR],
		recon:         STATUS_RST[ST_RECON],
		tma:           1'b0,
		ta:            STATUS_RST[ST_TA],
		tx_pending:    1'b0,
		rx_page:       5'h00,
		tx_page:       5'h00,
		rdata:         8'h00,
		irq:           1'b0,
		fbe_nak:       1'b0,
		fbe_ack:       1'b0,
		init_go:       1'b0,
		recon_timeout: 1'b0
	};

	tnss_state_t s_reg;
	tnss_state_t s_next;

	logic [7:0]         status_v;
	logic [2:0]         rate_shift;
	logic [TIMER_W-1:0] recon_base;

	tnss_timer_if #(.W(TIMER_W)) idle_if ();
	tnss_timer_if #(.W(TIMER_W)) recon_if ();

	// ----------------------------------------------------------------------
	// Status view
	// ----------------------------------------------------------------------
	// Bits 6 and 5 are reserved and bit 3 is the test bit; all read as zero.
	assign status_v = {s_reg.ri, 2'b00, s_reg.por, 1'b0, s_reg.recon, s_reg.tma, s_reg.ta};

	// ----------------------------------------------------------------------
	// Timers
	// ----------------------------------------------------------------------
	// Any high level on the synchronised receive line restarts the idle timer.
	assign idle_if.restart = s_reg.rx_sync;
	assign idle_if.run     = 1'b1;
	assign idle_if.period  = TIMER_W'(LINE_IDLE_CYCLES);

	always_comb begin
		case (s_reg.network_setup_two[S2_RCN_LSB +: 2])
			2'b00:   recon_base = TIMER_W'(RECON_CYCLES_0);
			2'b01:   recon_base = TIMER_W'(RECON_CYCLES_1);
			2'b10:   recon_base = TIMER_W'(RECON_CYCLES_2);
			default: recon_base = TIMER_W'(RECON_CYCLES_3);
		endcase
	end

	// Slower data rates stretch the period by the same power of two, up to a shift of RATE_SHIFT_MAX.
	assign rate_shift       = (i_rate_shift > 3'(RATE_SHIFT_MAX)) ? 3'(RATE_SHIFT_MAX) : i_rate_shift;
	assign recon_if.restart = i_token_rcvd;
	assign recon_if.run     = i_recon_timer_run;
	assign recon_if.period  = recon_base << rate_shift;

	tnss_timer #(.W(TIMER_W)) u_idle_timer (
		.i_clk_sys (i_clk_sys),
		.i_rst_n   (i_rst_n),
		.tif       (idle_if)
	);

	tnss_timer #(.W(TIMER_W)) u_recon_timer (
		.i_clk_sys (i_clk_sys),
		.i_rst_n   (i_rst_n),
		.tif       (recon_if)
	);

	// ----------------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------------
	always_comb begin
		s_next = s_reg;
		s_next.rx_meta = i_receive_input;
		s_next.rx_sync = s_reg.rx_meta;
		s_next.rdata = 8'h00;
		s_next.fbe_nak = 1'b0;
		s_next.fbe_ack = 1'b0;

		// Host writes; clears come first so events below win, except a token in a disable or soft-reset cycle and a packet stored while inhibited.
		if (i_wr) begin
			case (i_addr)
				ADDR_IMR: begin
					s_next.interrupt_mask_register = i_wdata;
				end
				ADDR_NODE_ID: begin
					s_next.node_id = i_wdata;
					if (i_wdata == 8'h00) begin
						s_next.por = 1'b1;
					end
				end
				ADDR_CONFIG: begin
					s_next.cfg = i_wdata;
					s_next.subsel = {1'b0, i_wdata[1:0]};
				end
				ADDR_SUBSEL: begin
					s_next.subsel = i_wdata[2:0];
				end
				ADDR_SUBREG: begin
					if (s_reg.subsel == SUBSEL_NETWORK_SETUP_TWO) begin
						s_next.network_setup_two = i_wdata;
					end
				end
				ADDR_COMMAND: begin
					case (i_wdata[2:0])
						CMD_DISABLE_TX: begin
							s_next.ta = 1'b1;
							s_next.tx_pending = 1'b0;
						end
						CMD_ENABLE_TX: begin
							s_next.tma = 1'b0;
							s_next.tx_pending = 1'b1;
							s_next.tx_page = i_wdata[CMD_PAGE_LSB +: 5];
						end
						CMD_ENABLE_RX: begin
							s_next.ri = 1'b0;
							s_next.rx_page = i_wdata[CMD_PAGE_LSB +: 5];
						end
						CMD_CLEAR_FLAGS: begin
							s_next.por = 1'b0;
							s_next.recon = 1'b0;
						end
						CMD_SOFT_RESET: begin
							s_next.ri = STATUS_RST[ST_RI];
							s_next.por = STATUS_RST[ST_POR];
							s_next.recon = STATUS_RST[ST_RECON];
							s_next.tma = 1'b0;
							s_next.ta = STATUS_RST[ST_TA];
							s_next.tx_pending = 1'b0;
						end
						default: begin
						end
					endcase
				end
				// The status address takes no write at all.
				default: begin
				end
			endcase
		end

		// Node events.
		if (i_pkt_stored && !s_reg.ri) begin
			s_next.ri = 1'b1;
		end
		if (idle_if.expired) begin
			s_next.recon = 1'b1;
		end
		if (i_tx_acked && !i_tx_broadcast) begin
			s_next.tma = 1'b1;
		end
		// A disable command in the token's cycle cancels the pending send,
		// so the transmitter stays available.
		if (i_token_rcvd && s_reg.tx_pending && s_next.tx_pending) begin
			s_next.ta = 1'b0;
			s_next.tx_pending = 1'b0;
		end
		if (i_tx_last_byte) begin
			s_next.ta = 1'b1;
		end

		// A free buffer enquiry is refused while reception is inhibited.
		if (i_fbe_enquiry) begin
			s_next.fbe_nak = s_reg.ri;
			s_next.fbe_ack = !s_reg.ri;
		end

		// Host reads; none of them alters a flag.
		if (i_rd) begin
			case (i_addr)
				ADDR_STATUS:  s_next.rdata = status_v;
				ADDR_IMR:     s_next.rdata = s_reg.interrupt_mask_register;
				ADDR_NODE_ID: s_next.rdata = s_reg.node_id;
				ADDR_CONFIG:  s_next.rdata = {s_reg.cfg[7:2], s_reg.subsel[1:0]};
				ADDR_SUBSEL:  s_next.rdata = {5'h00, s_reg.subsel};
				ADDR_SUBREG:  s_next.rdata = (s_reg.subsel == SUBSEL_NETWORK_SETUP_TWO) ? s_reg.network_setup_two : 8'h00;
				default:      s_next.rdata = 8'h00;
			endcase
		end

		s_next.init_go = i_init_req && (!s_reg.rx_sync || s_reg.network_setup_two[S2_NO_IDLE_INIT]);
		s_next.recon_timeout = recon_if.expired;
		s_next.irq = (s_next.ri & s_next.interrupt_mask_register[ST_RI])
			| (s_next.recon & s_next.interrupt_mask_register[ST_RECON])
			| (s_next.ta & s_next.interrupt_mask_register[ST_TA]);
	end

	// ----------------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------------
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			s_reg <= S_RST;
		end else begin
			s_reg <= s_next;
		end
	end

	// ----------------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------------
	assign o_rdata                   = s_reg.rdata;
	assign o_irq                     = s_reg.irq;
	assign o_receiver_inhibited      = s_reg.ri;
	assign o_fbe_nak                 = s_reg.fbe_nak;
	assign o_fbe_ack                 = s_reg.fbe_ack;
	assign o_clock_multiplier_select = s_reg.network_setup_two[S2_CKUP_LSB +: 2];
	assign o_fast_read_enable        = s_reg.network_setup_two[S2_FAST_READ];
	assign o_enhanced_timing_enable  = s_reg.network_setup_two[S2_ENH_TIMING];
	assign o_init_write_go           = s_reg.init_go;
	assign o_recon_timeout           = s_reg.recon_timeout;
	assign o_tx_pending              = s_reg.tx_pending;
	assign o_rx_page                 = s_reg.rx_page;
	assign o_tx_page                 = s_reg.tx_page;
	assign o_node_id                 = s_reg.node_id;

endmodule : tnss_status_setup

// [tb/tnss_host_model.sv]
// Host model that drives the plain register port of the status and setup bank.
// Assumes tasks are entered just after a rising edge; each returns 1 ns after one.
`timescale 1ns/100ps
module tnss_host_model (
	input  wire logic       i_clk_sys,
	input  wire logic [7:0] i_rdata,
	output logic      [2:0] o_addr,
	output logic      [7:0] o_wdata,
	output logic            o_wr,
	output logic            o_rd
);
	initial begin
		o_addr = 3'h0;
		o_wdata = 8'h00;
		o_wr = 1'b0;
		o_rd = 1'b0;
	end

	// A write is one strobe cycle; the address is held until the next edge.
	task automatic wr(input logic [2:0] a, input logic [7:0] v);
		o_addr <= a;
		o_wdata <= v;
		o_wr <= 1'b1;
		@(posedge i_clk_sys);
		o_wr <= 1'b0;
		@(posedge i_clk_sys);
		#1;
	endtask : wr

	// Read data stand only in the cycle after the strobe, so they are taken there.
	task automatic rd(input logic [2:0] a, output logic [7:0] v);
		o_addr <= a;
		o_rd <= 1'b1;
		@(posedge i_clk_sys);
		o_rd <= 1'b0;
		#1;
		v = i_rdata;
		@(posedge i_clk_sys);
		#1;
	endtask : rd
endmodule : tnss_host_model

// [tb/tnss_status_setup_monitor.sv]
// Port-level assertions for the status and second setup register bank.
// Assumes one clock domain and is bound to every instance of the top module.
`timescale 1ns/100ps
module tnss_status_setup_monitor
	import tnss_pkg::*;
(
	input wire logic       i_clk_sys,
	input wire logic       i_rst_n,
	input wire logic [2:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic       i_wr,
	input wire logic       i_rd,
	input wire logic [7:0] o_rdata,
	input wire logic       i_pkt_stored,
	input wire logic       i_fbe_enquiry,
	input wire logic       i_init_req,
	input wire logic       o_receiver_inhibited,
	input wire logic       o_fbe_nak,
	input wire logic       o_fbe_ack,
	input wire logic       o_init_write_go,
	input wire logic       o_recon_timeout,
	input wire logic       o_tx_pending
);
	default clocking cb @(posedge i_clk_sys);
	endclocking
	default disable iff (!i_rst_n);

	sequence s_cmd(logic [2:0] op);
		i_wr && i_addr == ADDR_COMMAND && i_wdata[2:0] == op;
	endsequence
	sequence s_enq(logic ri);
		i_fbe_enquiry && o_receiver_inhibited == ri && !i_wr && !i_pkt_stored;
	endsequence

	property p_ri_set;
		i_pkt_stored && !o_receiver_inhibited |=> o_receiver_inhibited;
	endproperty
	a_ri_set: assert property (p_ri_set) else $error("packet store left receiver enabled");
	property p_ri_hold;
		o_receiver_inhibited && !(i_wr && i_addr == ADDR_COMMAND) |=> o_receiver_inhibited;
	endproperty
	a_ri_hold: assert property (p_ri_hold) else $error("receiver inhibit dropped without command");
	property p_rx_en;
		s_cmd(CMD_ENABLE_RX) ##0 !i_pkt_stored |=> !o_receiver_inhibited;
	endproperty
	a_rx_en: assert property (p_rx_en) else $error("enable receive did not clear inhibit");
	property p_nak;
		s_enq(1'b1) |=> o_fbe_nak && !o_fbe_ack ##1 !o_fbe_nak;
	endproperty
	a_nak: assert property (p_nak) else $error("inhibited enquiry not answered negatively");
	property p_ack;
		s_enq(1'b0) |=> o_fbe_ack && !o_fbe_nak;
	endproperty
	a_ack: assert property (p_ack) else $error("enabled enquiry not acknowledged");
	property p_status_rd;
		i_rd && i_addr == ADDR_STATUS |=> o_rdata[7] == $past(o_receiver_inhibited) && o_rdata[6:5] == 2'b00
			&& !o_rdata[3];
	endproperty
	a_status_rd: assert property (p_status_rd) else $error("status read bits wrong");
	property p_rdata_idle;
		!i_rd |=> o_rdata == 8'h00;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read cycle");
	property p_init;
		!i_init_req |=> !o_init_write_go;
	endproperty
	a_init: assert property (p_init) else $error("init write without request");
	property p_recon_pulse;
		o_recon_timeout |=> !o_recon_timeout;
	endproperty
	a_recon_pulse: assert property (p_recon_pulse) else $error("timeout pulse too long");
	property p_tx_en;
		s_cmd(CMD_ENABLE_TX) |=> o_tx_pending;
	endproperty
	a_tx_en: assert property (p_tx_en) else $error("enable transmit not pending");
endmodule : tnss_status_setup_monitor

bind tnss_status_setup tnss_status_setup_monitor u_monitor (
	.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
	.o_rdata(o_rdata), .i_pkt_stored(i_pkt_stored), .i_fbe_enquiry(i_fbe_enquiry), .i_init_req(i_init_req),
	.o_receiver_inhibited(o_receiver_inhibited), .o_fbe_nak(o_fbe_nak), .o_fbe_ack(o_fbe_ack),
	.o_init_write_go(o_init_write_go), .o_recon_timeout(o_recon_timeout), .o_tx_pending(o_tx_pending)
);

// [tb/tnss_status_setup_tb.sv]
// Self-checking bench for the status and second setup register bank.
// Assumes short timer parameters; the host model drives registers, the bench drives core events.
`timescale 1ns/100ps
module tnss_status_setup_tb;
	import tnss_pkg::*;
	localparam int P[4] = '{64, 16, 8, 4};
	localparam logic [31:0] ROWS[6] = '{32'h02a5_02a5, 32'h033c_033c, 32'h0504_0504, 32'h077f_077f,
		32'h0699_0600, 32'h0600_0100};
	logic       clk = 1'b0;
	logic       rst_n = 1'b0;
	logic       line = 1'b1;
	logic       init_req = 1'b0;
	logic       run = 1'b0;
	logic [2:0] shift = 3'h0;
	logic [5:0] ev = 6'h00;
	logic [1:0] fbe;
	logic [2:0] addr;
	logic [7:0] wdata, rdata, d, node_id;
	logic       wr, rd, irq, ri, nak, ack, fast, enh, go, rto, pend;
	logic [1:0] cks;
	logic [4:0] rxp, txp;
	int         failures = 0;
	int         total_checks = 0;
	int         n;

	always #2 clk = ~clk;

	tnss_host_model host (.i_clk_sys(clk), .i_rdata(rdata), .o_addr(addr), .o_wdata(wdata), .o_wr(wr), .o_rd(rd));
	tnss_status_setup #(.LINE_IDLE_CYCLES(8), .RECON_CYCLES_0(P[0]), .RECON_CYCLES_1(P[1]),
		.RECON_CYCLES_2(P[2]), .RECON_CYCLES_3(P[3])) dut (
		.i_clk_sys(clk), .i_rst_n(rst_n), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
		.o_rdata(rdata), .i_receive_input(line), .i_pkt_stored(ev[0]), .i_tx_last_byte(ev[1]),
		.i_tx_acked(ev[2]), .i_tx_broadcast(ev[3]), .i_token_rcvd(ev[4]), .i_fbe_enquiry(ev[5]),
		.i_init_req(init_req), .i_recon_timer_run(run), .i_rate_shift(shift), .o_irq(irq),
		.o_receiver_inhibited(ri), .o_fbe_nak(nak), .o_fbe_ack(ack), .o_clock_multiplier_select(cks),
		.o_fast_read_enable(fast), .o_enhanced_timing_enable(enh), .o_init_write_go(go),
		.o_recon_timeout(rto), .o_tx_pending(pend), .o_rx_page(rxp), .o_tx_page(txp), .o_node_id(node_id));

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp) begin
			failures++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic st(input logic [7:0] exp);
		logic [7:0] v;
		host.rd(ADDR_STATUS, v);
		chk(v, exp);
	endtask : st

	// Events are one-cycle pulses; the enquiry answer is captured in the cycle after.
	task automatic pulse(input logic [5:0] m);
		ev <= m;
		@(posedge clk);
		ev <= 6'h00;
		#1;
		fbe = {nak, ack};
		@(posedge clk);
		#1;
	endtask : pulse

	task automatic stop_test;
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : stop_test

	initial begin
		#200000;
		failures++;
		stop_test();
	end

	initial begin
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		st(8'h91);
		chk(8'(ri), 8'h01);
		host.rd(ADDR_CONFIG, d);
		chk(d, 8'h18);
		foreach (ROWS[i]) begin
			host.wr(ROWS[i][26:24], ROWS[i][23:16]);
			host.rd(ROWS[i][10:8], d);
			chk(d, ROWS[i][7:0]);
		end
		chk(8'({cks, fast, enh}), 8'h0f);
		chk(node_id, 8'h3c);
		chk(8'(irq), 8'h01);
		host.wr(ADDR_STATUS, 8'h00);
		st(8'h91);
		st(8'h91);
		host.wr(ADDR_IMR, 8'h00);
		chk(8'(irq), 8'h00);
		host.wr(ADDR_COMMAND, 8'h04);
		st(8'h81);
		host.wr(ADDR_NODE_ID, 8'h00);
		st(8'h91);
		host.wr(ADDR_COMMAND, 8'h04);
		host.wr(ADDR_IMR, 8'h80);
		chk(8'(irq), 8'h01);
		host.wr(ADDR_COMMAND, 8'h5b);
		chk(8'({ri, irq, rxp}), 8'h0b);
		pulse(6'h20);
		chk(8'(fbe), 8'h01);
		pulse(6'h01);
		chk(8'({ri, irq}), 8'h03);
		pulse(6'h20);
		chk(8'(fbe), 8'h02);
		host.wr(ADDR_COMMAND, 8'h8a);
		chk(8'({pend, txp}), 8'h31);
		st(8'h81);
		pulse(6'h10);
		st(8'h80);
		pulse(6'h06);
		st(8'h83);
		host.wr(ADDR_COMMAND, 8'h8a);
		st(8'h81);
		pulse(6'h10);
		pulse(6'h0e);
		st(8'h81);
		host.wr(ADDR_COMMAND, 8'h8a);
		pulse(6'h10);
		host.wr(ADDR_COMMAND, 8'h01);
		st(8'h81);
		line <= 1'b0;
		repeat (20) @(posedge clk);
		line <= 1'b1;
		repeat (4) @(posedge clk);
		st(8'h85);
		host.wr(ADDR_COMMAND, 8'h04);
		st(8'h81);
		init_req <= 1'b1;
		repeat (3) @(posedge clk);
		#1;
		chk(8'(go), 8'h01);
		host.wr(ADDR_SUBREG, 8'h00);
		chk(8'(go), 8'h00);
		line <= 1'b0;
		repeat (6) @(posedge clk);
		#1;
		chk(8'(go), 8'h01);
		line <= 1'b1;
		init_req <= 1'b0;
		host.wr(ADDR_CONFIG, 8'h18);
		host.rd(ADDR_SUBSEL, d);
		chk(d, 8'h00);
		host.wr(ADDR_SUBREG, 8'h55);
		host.wr(ADDR_SUBSEL, 8'h04);
		host.rd(ADDR_SUBREG, d);
		chk(d, 8'h00);
		run <= 1'b1;
		for (int s = 0; s < 4; s++) begin
			// The shortest setting assumes node 255 is on the network.
			host.wr(ADDR_SUBREG, 8'(s << 5));
			shift <= (s == 3) ? 3'h2 : 3'h0;
			ev <= 6'h10;
			@(posedge clk);
			ev <= 6'h00;
			#1;
			n = 0;
			while (rto !== 1'b1 && n < 2000) begin
				@(posedge clk);
				#1;
				n++;
			end
			chk(8'(n >= (P[s] << shift) && n <= (P[s] << shift) + 3), 8'h01);
		end
		run <= 1'b0;
		host.wr(ADDR_COMMAND, 8'h05);
		st(8'h91);
		host.rd(ADDR_SUBREG, d);
		chk(d, 8'h60);
		chk(8'({cks, fast, enh}), 8'h00);
		stop_test();
	end
endmodule : tnss_status_setup_tb
